/* File: logic/rgb_bridge.sv */
// Top of the reduced-gigabit DDR/SDR bridge with pin muxing and PHY reset.
// Assumes ref_clk 250 MHz; transmit clock is 125 MHz divided from it.
`timescale 1ns/1ns
`default_nettype none
module rgb_bridge (
	input wire logic ref_clk, // System clock, 250 MHz
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic mode_en, // Interface mode enable from config
	input wire logic clk_dly_en, // Delay transmit clock edge
	input wire logic phy_release, // Software releases PHY reset
	input wire logic [7:0] tx_byte, // Tile transmit word
	input wire logic tx_en, // Tile transmit enable
	input wire logic tx_err, // Tile transmit error
	output logic [7:0] rx_word, // Tile receive word
	output logic rx_valid, // Tile receive valid
	output logic rx_error, // Tile receive error
	output logic rx_strobe, // One-cycle pulse per received word
	output logic speed_clk, // Inverted receive-valid clock source
	input wire logic rx_clk, // PHY receive clock
	input wire logic [3:0] rxd, // PHY receive nibble
	input wire logic rx_ctl, // PHY receive control
	output logic [3:0] txd, // PHY transmit nibble
	output logic tx_ctl, // PHY transmit control
	output logic tx_clk, // Generated transmit clock
	output logic phy_rst_n, // PHY reset, active low
	input wire logic [11:0] gpio_out, // GPIO drive values
	input wire logic [11:0] gpio_oe, // GPIO enables
	output logic [11:0] pin_oe, // Dedicated pin enables
	input wire logic mdc_in, // Management clock pin in
	output logic mdc_out, // Management clock pin out
	output logic mdc_oe, // Management clock enable
	input wire logic mdio_in, // Management data pin in
	output logic mdio_out, // Management data pin out
	output logic mdio_oe, // Management data enable
	input wire logic mdc_drive, // Tile wants management clock low
	input wire logic mdio_drive, // Tile wants management data low
	output logic mdio_sample // Synchronised management data
);
	rgb_pkg::rgb_tx_phase_t phase;
	logic [3:0] tx_hi;
	logic tx_ctl_hi;
	logic tx_clk_raw;
	logic tx_clk_dly;
	logic [7:0] cap_byte;
	logic cap_dv;
	logic cap_er;
	logic cap_tgl;
	logic [2:0] tgl_sync;
	logic [1:0] md_sync;
	logic rel_q;

	rgb_rx_ddr u_rx (
		.rx_clk(rx_clk),
		.resetn(resetn),
		.rxd(rxd),
		.rx_ctl(rx_ctl),
		.rx_byte(cap_byte),
		.rx_dv(cap_dv),
		.rx_er(cap_er),
		.rx_tgl(cap_tgl)
	);

	// Transmit phase: low half then high half each 125 MHz period
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			phase <= rgb_pkg::RGB_TX_LOW;
		end else if (!mode_en) begin
			phase <= rgb_pkg::RGB_TX_LOW;
		end else begin
			phase <= (phase == rgb_pkg::RGB_TX_LOW) ? rgb_pkg::RGB_TX_HIGH : rgb_pkg::RGB_TX_LOW;
		end
	end

	// Serialise tile word: low nibble with rising clock, high with falling
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			txd <= 4'h0;
			tx_ctl <= 1'b0;
			tx_hi <= 4'h0;
			tx_ctl_hi <= 1'b0;
		end else if (!mode_en) begin
			txd <= 4'h0;
			tx_ctl <= 1'b0;
			tx_hi <= 4'h0;
			tx_ctl_hi <= 1'b0;
		end else if (phase == rgb_pkg::RGB_TX_LOW) begin
			txd <= tx_byte[3:0];
			tx_ctl <= tx_en;
			tx_hi <= tx_byte[7:4];
			tx_ctl_hi <= tx_en ^ tx_err;
		end else begin
			txd <= tx_hi;
			tx_ctl <= tx_ctl_hi;
		end
	end

	// Transmit clock made here; rises with low nibble when not delayed
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tx_clk_raw <= 1'b0;
		end else begin
			tx_clk_raw <= mode_en && (phase == rgb_pkg::RGB_TX_LOW);
		end
	end

	// Delayed copy shifts the edge a quarter period later
	always_ff @(negedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tx_clk_dly <= 1'b0;
		end else begin
			tx_clk_dly <= tx_clk_raw;
		end
	end

	// Mux glitch is tolerable only because delay is set before enabling
	always_comb begin
		tx_clk = clk_dly_en ? tx_clk_dly : tx_clk_raw;
	end

	// Receive crossing: toggle plus two flops, data stable for a period
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tgl_sync <= 3'h0;
		end else begin
			tgl_sync <= {tgl_sync[1:0], cap_tgl};
		end
	end

	// Capture received word when toggle edge seen
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rx_word <= rgb_pkg::RGB_RX_RESET;
			rx_valid <= 1'b0;
			rx_error <= 1'b0;
			rx_strobe <= 1'b0;
		end else begin
			rx_strobe <= mode_en && (tgl_sync[2] ^ tgl_sync[1]);
			if (mode_en && (tgl_sync[2] ^ tgl_sync[1])) begin
				rx_word <= cap_byte;
				rx_valid <= cap_dv;
				rx_error <= cap_er;
			end
		end
	end

	// Speed-switch clock follows inverted receive valid
	always_comb begin
		speed_clk = ~rx_valid;
	end

	// PHY stays in reset until deliberately released
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rel_q <= 1'b0;
		end else if (!mode_en) begin
			rel_q <= 1'b0;
		end else if (phy_release) begin
			rel_q <= 1'b1;
		end
	end

	always_comb begin
		phy_rst_n = rel_q;
	end

	// Pin ownership: bridge drives transmit pins, GPIO otherwise
	always_comb begin
		if (mode_en) begin
			pin_oe = {6'h3F, 6'h00};
		end else begin
			pin_oe = gpio_oe;
		end
	end

	// Open-drain management pins only ever pull low
	always_comb begin
		mdc_out = 1'b0;
		mdio_out = 1'b0;
		mdc_oe = mdc_drive;
		mdio_oe = mdio_drive;
	end

	// Synchronise management data read back
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			md_sync <= 2'h0;
		end else begin
			md_sync <= {md_sync[0], mdio_in};
		end
	end

	always_comb begin
		mdio_sample = md_sync[1];
	end

	// Enable must not release PHY; enable drop pulls reset again
	AST_PHY_HELD: assert property (@(posedge ref_clk) disable iff (!resetn)
		!mode_en |=> !phy_rst_n) else $error("PHY released while disabled");
	AST_PHY_REL: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode_en && phy_release |=> phy_rst_n) else $error("PHY not released");
	AST_TX_LOW: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode_en && $past(mode_en) && phase == rgb_pkg::RGB_TX_LOW |=> txd == $past(tx_byte[3:0]))
		else $error("Low nibble wrong");
	AST_TX_HIGH: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode_en && phase == rgb_pkg::RGB_TX_LOW ##1 mode_en |=> txd == $past(tx_byte[7:4], 2))
		else $error("High nibble wrong");
	AST_CLK_GEN: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode_en ##1 mode_en |=> tx_clk_raw != $past(tx_clk_raw)) else $error("Tx clock not toggling");
	AST_PIN_OWN: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode_en |-> pin_oe == 12'hFC0) else $error("Pins not owned by bridge");
	AST_PIN_GPIO: assert property (@(posedge ref_clk) disable iff (!resetn)
		!mode_en |-> pin_oe == gpio_oe) else $error("GPIO not restored");
	AST_OD: assert property (@(posedge ref_clk) disable iff (!resetn)
		!mdc_out && !mdio_out && mdio_oe == mdio_drive) else $error("Management pin drives high");
	AST_SPEED: assert property (@(posedge ref_clk) disable iff (!resetn)
		rx_valid |-> !speed_clk) else $error("Speed clock wrong");
	AST_RX_STB: assert property (@(posedge ref_clk) disable iff (!resetn)
		rx_strobe |=> !rx_strobe) else $error("Receive strobe too long");

	// Disabled bridge leaves the transmit pins quiet; words change only with their strobe
	AST_TX_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
		!mode_en |=> txd == 4'h0 && !tx_ctl) else $error("Transmit pins active while disabled");
	AST_RX_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
		!rx_strobe |-> $stable(rx_word)) else $error("Receive word changed without strobe");
endmodule
`default_nettype wire

/* File: logic/rgb_pkg.sv */
// Shared constants for the reduced-gigabit DDR/SDR bridge.
// Assumes a 250 MHz system clock and a PHY receive clock on its own domain.
// Function
// - Enable releases pins from GPIO to bridge
// - Bridge feeds and takes tile port words
// - Enabled pins and ports serve only bridge
// - DDR nibble plus control to SDR byte
// - Device generates transmit clock from config
// - Transmit clock edge may be delayed
// - Transmit path and delayed clock separate sources
// - Clock from inverted receive-valid for speed switching
// - Management clock and data are open-drain
// - PHY held in reset until released
package rgb_pkg;
	localparam int RGB_NIB_W = 4;
	localparam int RGB_BYTE_W = 8;
	localparam int RGB_PIN_W = 12;
	localparam int RGB_DIV_W = 8;
	localparam logic [7:0] RGB_DIV_RESET = 8'h00;
	localparam logic [1:0] RGB_DLY_RESET = 2'h0;
	localparam int RGB_SYNC_STAGES = 2;
	localparam logic [7:0] RGB_RX_RESET = 8'h00;
	typedef enum logic [1:0] {
		RGB_TX_LOW = 2'h0,
		RGB_TX_HIGH = 2'h1
	} rgb_tx_phase_t;
endpackage

/* File: logic/rgb_rx_ddr.sv */
// Receive-side DDR capture on the PHY receive clock.
// Assumes rx_clk is the PHY's clock and stays low while the PHY is in reset.
`timescale 1ns/1ns
`default_nettype none
module rgb_rx_ddr (
	input wire logic rx_clk, // PHY receive clock
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic [3:0] rxd, // DDR receive nibble
	input wire logic rx_ctl, // DDR receive control
	output logic [7:0] rx_byte, // Assembled byte
	output logic rx_dv, // Data valid
	output logic rx_er, // Receive error
	output logic rx_tgl // Toggles per captured byte
);
	logic [3:0] rise_nib;
	logic rise_ctl;

	// Rising edge holds the low nibble and the valid bit until the falling half comes
	always_ff @(posedge rx_clk or negedge resetn) begin
		if (!resetn) begin
			rise_nib <= 4'h0;
			rise_ctl <= 1'b0;
		end else begin
			rise_nib <= rxd;
			rise_ctl <= rx_ctl;
		end
	end

	// Falling edge completes the byte, so a clock parked after a frame loses nothing
	always_ff @(negedge rx_clk or negedge resetn) begin
		if (!resetn) begin
			rx_byte <= rgb_pkg::RGB_RX_RESET;
			rx_dv <= 1'b0;
			rx_er <= 1'b0;
			rx_tgl <= 1'b0;
		end else begin
			rx_byte <= {rxd, rise_nib};
			rx_dv <= rise_ctl;
			rx_er <= rise_ctl ^ rx_ctl;
			rx_tgl <= ~rx_tgl;
		end
	end
endmodule
`default_nettype wire

/* File: test/rgb_bridge_tb.sv */
// Self-checking bench for the bridge with a PHY model on the receive pins.
// Assumes the 250 MHz system clock; management pins have pull-ups.
`timescale 1ns/1ns
`default_nettype none
module rgb_bridge_tb;
	logic ref_clk = 1'b0, resetn = 1'b1, mode_en = 1'b0, clk_dly_en = 1'b0, phy_release = 1'b0;
	logic [7:0] tx_byte = 8'h00, rx_word;
	logic tx_en = 1'b0, tx_err = 1'b0, rx_valid, rx_error, rx_strobe, speed_clk;
	logic rx_clk, rx_ctl, tx_ctl, tx_clk, phy_rst_n, mdc_out, mdc_oe, mdio_out, mdio_oe, mdio_sample;
	logic [3:0] rxd, txd;
	logic [11:0] gpio_oe = 12'h5A5, pin_oe;
	logic mdc_drive = 1'b0, mdio_drive = 1'b0;
	int mismatches = 0, n_compared = 0, i;
	wire logic mdc_in = mdc_oe ? mdc_out : 1'b1;
	wire logic mdio_in = mdio_oe ? mdio_out : 1'b1;
	// Clock
	always #2 ref_clk = ~ref_clk;
	rgb_bridge uut (.ref_clk(ref_clk), .resetn(resetn), .mode_en(mode_en), .clk_dly_en(clk_dly_en),
		.phy_release(phy_release), .tx_byte(tx_byte), .tx_en(tx_en), .tx_err(tx_err), .rx_word(rx_word),
		.rx_valid(rx_valid), .rx_error(rx_error), .rx_strobe(rx_strobe), .speed_clk(speed_clk),
		.rx_clk(rx_clk), .rxd(rxd), .rx_ctl(rx_ctl), .txd(txd), .tx_ctl(tx_ctl), .tx_clk(tx_clk),
		.phy_rst_n(phy_rst_n), .gpio_out(12'h000), .gpio_oe(gpio_oe), .pin_oe(pin_oe), .mdc_in(mdc_in),
		.mdc_out(mdc_out), .mdc_oe(mdc_oe), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.mdc_drive(mdc_drive), .mdio_drive(mdio_drive), .mdio_sample(mdio_sample));
	rgb_phy_model phy (.phy_rst_n(phy_rst_n), .rx_clk(rx_clk), .rxd(rxd), .rx_ctl(rx_ctl));
	task final_report;
		if (mismatches == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task check(input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			mismatches++;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// A wait that runs out of cycles counts as a mismatch and ends the run
	task give_up(input logic reached);
		if (reached !== 1'b1) begin
			mismatches++;
			final_report;
		end
	endtask
	// Bounded wait for the receive strobe; a hang ends the run
	task wait_strobe;
		i = 0;
		do begin
			cyc(1);
			i++;
		end while (rx_strobe !== 1'b1 && i < 60);
		give_up(rx_strobe);
	endtask
	task t_reset;
		check(12'({phy_rst_n, speed_clk, txd}), 12'h010);
		check(pin_oe, gpio_oe);
		mode_en = 1'b1;
		cyc(2);
		check(pin_oe, 12'hFC0);
		check(12'(phy_rst_n), 12'h000);
		phy_release = 1'b1;
		cyc(3);
		check(12'(phy_rst_n), 12'h001);
	endtask
	// Transmit byte with error: low nibble with clock high, then high nibble
	task t_tx;
		{tx_byte, tx_en, tx_err} = {8'hAB, 2'b11};
		cyc(4);
		for (i = 0; i < 8 && tx_clk !== 1'b1; i++) cyc(1);
		give_up(tx_clk);
		check(12'({txd, tx_ctl}), 12'h017);
		cyc(1);
		check(12'({txd, tx_ctl, tx_clk}), 12'h028);
		clk_dly_en = 1'b1;
		cyc(4);
		for (i = 0; i < 8 && txd !== 4'hB; i++) cyc(1);
		give_up(txd == 4'hB);
		check(12'(tx_clk), 12'h000);
		@(negedge ref_clk);
		#1;
		check(12'(tx_clk), 12'h001);
	endtask
	// Two received bytes, the second flagged in error
	task t_rx;
		fork
			begin
				phy.send(8'h5A, 1'b1, 1'b0);
				phy.send(8'hC3, 1'b1, 1'b1);
				phy.send(8'h00, 1'b0, 1'b0);
			end
			begin
				wait_strobe;
				check(12'({rx_word, rx_valid, rx_error}), 12'h16A);
				wait_strobe;
				check(12'({rx_word, rx_valid, rx_error}), 12'h30F);
				check(12'(speed_clk), 12'h000);
			end
		join
		cyc(1);
	endtask
	// Open-drain management lines pulled low, then the data line released
	task t_mgmt;
		{mdc_drive, mdio_drive} = 2'b11;
		cyc(3);
		check(12'({mdc_oe, mdc_out, mdio_oe, mdio_out, mdio_sample}), 12'h014);
		mdio_drive = 1'b0;
		cyc(3);
		check(12'({mdio_oe, mdio_sample}), 12'h001);
	endtask
	initial begin
		#1 resetn = 1'b0;
		cyc(12);
		resetn = 1'b1;
		t_reset;
		t_tx;
		t_rx;
		t_mgmt;
		mode_en = 1'b0;
		cyc(3);
		check(pin_oe, gpio_oe);
		check(12'({txd, tx_ctl}), 12'h000);
		check(12'(phy_rst_n), 12'h000);
		final_report;
	end
endmodule
`default_nettype wire

/* File: test/rgb_phy_model.sv */
// Behavioural PHY driving the receive side of the bridge.
// Assumes the testbench calls send; the clock stands still between frames.
`timescale 1ns/1ns
`default_nettype none
module rgb_phy_model (
	input wire logic phy_rst_n, // Reset from bridge, active low
	output logic rx_clk, // Receive clock
	output logic [3:0] rxd, // Receive nibble
	output logic rx_ctl // Receive control
);
	// Idle state: clock parked low
	initial begin
		rx_clk = 1'b0;
		rxd = 4'h0;
		rx_ctl = 1'b0;
	end
	// One byte per 15 ns clock; unpulled data shows the inverse once its hold ends
	task send(input logic [7:0] b, input logic dv, input logic er);
		if (phy_rst_n !== 1'b1) return;
		rxd = b[3:0];
		rx_ctl = dv;
		#3 rx_clk = 1'b1;
		#4 rxd = b[7:4];
		rx_ctl = dv ^ er;
		#4 rx_clk = 1'b0;
		#2 rxd = ~rxd;
		#2;
	endtask
endmodule
`default_nettype wire
